//--- shared/tpta_map.vh
/*
 * Register map, field positions, reset values and timing constants
 * for the thermal event pin, assertion timer and alert block.
 * Assumes an 8-bit register port and a 25 MHz core clock.
 */
`ifndef TPTA_MAP_VH
`define TPTA_MAP_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define TPTA_A_STATUS_TWO   8'h42
`define TPTA_A_R1_CFG       8'h5F
`define TPTA_A_LOC_CFG      8'h60
`define TPTA_A_R2_CFG       8'h61
`define TPTA_A_R1_CRIT      8'h6A
`define TPTA_A_LOC_CRIT     8'h6B
`define TPTA_A_R2_CRIT      8'h6C
`define TPTA_A_MASK_TWO     8'h75
`define TPTA_A_CFG_THREE    8'h78
`define TPTA_A_TIMER        8'h79
`define TPTA_A_TIMER_LIMIT  8'h7A
`define TPTA_A_CFG_FOUR     8'h7D

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define TPTA_B_ALERT_EN     0
`define TPTA_B_THERMAL_EVENT_PIN_EN     1
`define TPTA_B_FULL_SPEED_OVERRIDE        2
`define TPTA_B_CH_OUT_EN    3
`define TPTA_B_F4           5
`define TPTA_B_TEMP_SIGN    9
`define TPTA_SEL_HI         1
`define TPTA_SEL_LO         0

// Ninth pin function codes
`define TPTA_SEL_TACH       2'h0
`define TPTA_SEL_THERMAL_EVENT_PIN      2'h1
`define TPTA_SEL_ALERT      2'h2
`define TPTA_SEL_GPIO       2'h3

// ----------------------------------------------------------------
// Reset values and constants
// ----------------------------------------------------------------
`define TPTA_RST_BYTE       8'h00
`define TPTA_ZERO_BYTE      8'h00
`define TPTA_ONE_BYTE       8'h01
`define TPTA_FULL_BYTE      8'hFF
`define TPTA_CRIT_OFS_MAX   8'h80
`define TPTA_FRAC_ZERO      2'h0
`define TPTA_STICKY_USED    8'hFE

// ----------------------------------------------------------------
// Timing: timer resolution 22.76 ms, clock period 40 ns
// ----------------------------------------------------------------
`define TPTA_TMR_RES_NS     22760000
`define TPTA_CLK_PERIOD_NS  40

`endif

//--- hdl/tpta_top.v
/*
 * Thermal event pin block: ninth-pin function select, alert output on
 * the first multi-use pin or the ninth pin, cumulative assertion timer
 * with limit compare, sticky interrupt status two with mask, critical
 * temperature pin drive and the fan full-speed override request.
 * Assumes a simple synchronous register port (the serial bus engine
 * sits outside), temperatures from an ADC with a per-cycle update
 * pulse, and external open-drain resolution of the pins.
 */
`timescale 1ns/1ps
`default_nettype none
`include "tpta_map.vh"

module tpta_top #(
    parameter TICK_CYCLES = `TPTA_TMR_RES_NS / `TPTA_CLK_PERIOD_NS
) (
    input wire clk,
    input wire nrst,
    input wire [7:0] reg_addr,
    input wire reg_wr,
    input wire [7:0] reg_wdata,
    input wire reg_rd,
    output reg [7:0] reg_rdata_q,
    input wire pin9_i,
    output reg pin9_oe_q,
    output reg pin5_oe_q,
    output reg fourth_tach_input_q,
    input wire [9:0] temp_r1,
    input wire [9:0] temp_loc,
    input wire [9:0] temp_r2,
    input wire temp_update,
    input wire twos_mode,
    input wire fan_manual_mode,
    input wire [7:0] fan_manual_duty,
    input wire fan_above_start,
    input wire diode1_fault,
    input wire diode2_fault,
    input wire first_cooler_fail,
    input wire second_cooler_fail,
    input wire third_cooler_fail,
    input wire fourth_cooler_fail,
    output reg fan_full_speed_q
);

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    reg [7:0] r1_cfg_q;
    reg [7:0] loc_cfg_q;
    reg [7:0] r2_cfg_q;
    reg [7:0] r1_crit_q;
    reg [7:0] loc_crit_q;
    reg [7:0] r2_crit_q;
    reg [7:0] mask_two_q;
    reg [7:0] cfg_three_q;
    reg [7:0] tmr_limit_q;
    reg [7:0] cfg_four_q;

    // Timer state
    reg [19:0] presc_q;
    reg [7:0] units_q;
    reg seen_q;

    // Status, pin drive and synchroniser
    reg [7:0] status_q;
    reg [2:0] ch_over_q;
    reg sync1_q;
    reg sync2_q;

    wire [1:0] pin9_sel;
    wire thermal_event_pin_mode;
    wire pin_low;
    wire timer_rd;
    wire status_rd;
    wire [7:0] tmr_val;
    wire tmr_over;
    wire fans_running;
    wire thermal_event_pin_drive;
    wire [7:0] cond;
    wire [7:0] status_d;
    wire alert;
    wire tick;
    wire [19:0] tick_last;
    wire [2:0] ch_en;
    wire [2:0] ch_over_d;

    localparam [31:0] TICK_LAST32 = TICK_CYCLES - 1;
    assign tick_last = TICK_LAST32[19:0];

    // ------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------
    // Pin function select and thermal enable gate the timer, pin drive and fan override below; the select alone gates the tach
    assign pin9_sel = cfg_four_q[`TPTA_SEL_HI:`TPTA_SEL_LO];
    assign thermal_event_pin_mode = (pin9_sel == `TPTA_SEL_THERMAL_EVENT_PIN) &
                        cfg_three_q[`TPTA_B_THERMAL_EVENT_PIN_EN];
    // Active-low pin: asserted when the synchronised level is low
    assign pin_low = thermal_event_pin_mode & ~sync2_q;
    assign timer_rd = reg_rd & (reg_addr == `TPTA_A_TIMER);
    assign status_rd = reg_rd & (reg_addr == `TPTA_A_STATUS_TWO);

    // ------------------------------------------------------------
    // Pin synchroniser
    // ------------------------------------------------------------
    // Two stages; only the second stage is looked at by logic
    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            sync1_q <= 1'b1;
            sync2_q <= 1'b1;
        end
        else
        begin
            sync1_q <= pin9_i;
            sync2_q <= sync1_q;
        end
    end

    // ------------------------------------------------------------
    // Assertion timer
    // ------------------------------------------------------------
    // First assertion shows as 1; after that units carry the count
    assign tmr_val = ((units_q == `TPTA_ZERO_BYTE) & seen_q) ?
                     `TPTA_ONE_BYTE : units_q;
    assign tick = pin_low & (presc_q == tick_last);
    assign tmr_over = thermal_event_pin_mode & (tmr_val > tmr_limit_q);

    // Prescaler holds while the pin is released so time accumulates
    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            presc_q <= 20'h00000;
            units_q <= `TPTA_RST_BYTE;
            seen_q <= 1'b0;
        end
        else if (timer_rd)
        begin
            // Clear on read; restart at once if still asserted
            presc_q <= 20'h00000;
            units_q <= `TPTA_ZERO_BYTE;
            seen_q <= pin_low;
        end
        else if (pin_low)
        begin
            seen_q <= 1'b1;
            if (tick)
            begin
                presc_q <= 20'h00000;
                // Saturate: a full count must not wrap to a small value
                if (units_q != `TPTA_FULL_BYTE)
                begin
                    units_q <= units_q + `TPTA_ONE_BYTE;
                end
            end
            else
            begin
                presc_q <= presc_q + 20'h00001;
            end
        end
    end

    // ------------------------------------------------------------
    // Critical temperature pin drive
    // ------------------------------------------------------------
    // Channel enables from bit 3 of each channel configuration
    assign ch_en = {r2_cfg_q[`TPTA_B_CH_OUT_EN],
                    loc_cfg_q[`TPTA_B_CH_OUT_EN],
                    r1_cfg_q[`TPTA_B_CH_OUT_EN]};

    // Low limits switch the channel off in either coding
    function crit_ok;
        input [7:0] lim;
        input tc;
        begin
            if (tc)
            begin
                crit_ok = ~lim[7] & (lim != `TPTA_ZERO_BYTE);
            end
            else
            begin
                crit_ok = lim > `TPTA_CRIT_OFS_MAX;
            end
        end
    endfunction

    // Temps carry two quarter-degree bits; strictly above means +0.25 C
    // Signed coding: a valid limit is positive, so a negative temp is never over
    assign ch_over_d[0] = ch_en[0] & crit_ok(r1_crit_q, twos_mode) &
                          (temp_r1 > {r1_crit_q, `TPTA_FRAC_ZERO}) &
                          ~(twos_mode & temp_r1[`TPTA_B_TEMP_SIGN]);
    assign ch_over_d[1] = ch_en[1] & crit_ok(loc_crit_q, twos_mode) &
                          (temp_loc > {loc_crit_q, `TPTA_FRAC_ZERO}) &
                          ~(twos_mode & temp_loc[`TPTA_B_TEMP_SIGN]);
    assign ch_over_d[2] = ch_en[2] & crit_ok(r2_crit_q, twos_mode) &
                          (temp_r2 > {r2_crit_q, `TPTA_FRAC_ZERO}) &
                          ~(twos_mode & temp_r2[`TPTA_B_TEMP_SIGN]);

    // Re-checked once per monitoring cycle, so drive lasts one cycle minimum
    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            ch_over_q <= 3'h0;
        end
        else if (temp_update)
        begin
            ch_over_q <= ch_over_d;
        end
    end

    assign thermal_event_pin_drive = thermal_event_pin_mode & (|ch_over_q);

    // ------------------------------------------------------------
    // Interrupt status two, sticky
    // ------------------------------------------------------------
    // Bit 5 follows the timer in thermal mode, fan four otherwise
    assign cond = {diode2_fault, diode1_fault,
                   thermal_event_pin_mode ? tmr_over : fourth_cooler_fail,
                   third_cooler_fail, second_cooler_fail,
                   first_cooler_fail, thermal_event_pin_drive, 1'b0};

    // Set wins over a status read clear; a status read clears only vanished causes
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1)
        begin : g_sticky
            if (gi == `TPTA_B_F4)
            begin : g_f4
                // Timer read clears outright; a timer still over re-sets next cycle
                assign status_d[gi] = (timer_rd & thermal_event_pin_mode) ? 1'b0 :
                    (cond[gi] | (status_q[gi] & ~(status_rd & ~cond[gi])));
            end
            else
            begin : g_other
                assign status_d[gi] = cond[gi] |
                    (status_q[gi] & ~(status_rd & ~cond[gi]));
            end
        end
    endgenerate

    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            status_q <= `TPTA_RST_BYTE;
        end
        else
        begin
            status_q <= status_d & `TPTA_STICKY_USED;
        end
    end

    // Masked sources still set status; only the alert is gated
    assign alert = |(status_q & ~mask_two_q);

    // ------------------------------------------------------------
    // Fan override
    // ------------------------------------------------------------
    // A stopped fan is never kicked to full speed by the pin
    assign fans_running = fan_manual_mode ?
                          (fan_manual_duty != `TPTA_ZERO_BYTE) :
                          fan_above_start;

    // ------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------
    // Open-drain enables: high means pull the pin low
    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            pin5_oe_q <= 1'b0;
            pin9_oe_q <= 1'b0;
            fourth_tach_input_q <= 1'b1;
            fan_full_speed_q <= 1'b0;
        end
        else
        begin
            pin5_oe_q <= cfg_three_q[`TPTA_B_ALERT_EN] & alert;
            // Ninth pin: alert function or critical-temperature drive
            pin9_oe_q <= ((pin9_sel == `TPTA_SEL_ALERT) & alert) |
                         thermal_event_pin_drive;
            fourth_tach_input_q <= (pin9_sel == `TPTA_SEL_TACH) ?
                                   sync2_q : 1'b1;
            fan_full_speed_q <= cfg_three_q[`TPTA_B_FULL_SPEED_OVERRIDE] & pin_low &
                                fans_running;
        end
    end

    // ------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------
    // Writes to read-only or unmapped offsets are dropped
    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            r1_cfg_q <= `TPTA_RST_BYTE;
            loc_cfg_q <= `TPTA_RST_BYTE;
            r2_cfg_q <= `TPTA_RST_BYTE;
            r1_crit_q <= `TPTA_RST_BYTE;
            loc_crit_q <= `TPTA_RST_BYTE;
            r2_crit_q <= `TPTA_RST_BYTE;
            mask_two_q <= `TPTA_RST_BYTE;
            cfg_three_q <= `TPTA_RST_BYTE;
            tmr_limit_q <= `TPTA_RST_BYTE;
            cfg_four_q <= `TPTA_RST_BYTE;
        end
        else if (reg_wr)
        begin
            case (reg_addr)
                `TPTA_A_R1_CFG: r1_cfg_q <= reg_wdata;
                `TPTA_A_LOC_CFG: loc_cfg_q <= reg_wdata;
                `TPTA_A_R2_CFG: r2_cfg_q <= reg_wdata;
                `TPTA_A_R1_CRIT: r1_crit_q <= reg_wdata;
                `TPTA_A_LOC_CRIT: loc_crit_q <= reg_wdata;
                `TPTA_A_R2_CRIT: r2_crit_q <= reg_wdata;
                `TPTA_A_MASK_TWO: mask_two_q <= reg_wdata;
                `TPTA_A_CFG_THREE: cfg_three_q <= reg_wdata;
                `TPTA_A_TIMER_LIMIT: tmr_limit_q <= reg_wdata;
                `TPTA_A_CFG_FOUR: cfg_four_q <= reg_wdata;
                default: cfg_four_q <= cfg_four_q;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Register reads
    // ------------------------------------------------------------
    // Data lands one cycle after the read strobe; unmapped reads 0
    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            reg_rdata_q <= `TPTA_RST_BYTE;
        end
        else if (reg_rd)
        begin
            case (reg_addr)
                `TPTA_A_STATUS_TWO: reg_rdata_q <= status_q;
                `TPTA_A_R1_CFG: reg_rdata_q <= r1_cfg_q;
                `TPTA_A_LOC_CFG: reg_rdata_q <= loc_cfg_q;
                `TPTA_A_R2_CFG: reg_rdata_q <= r2_cfg_q;
                `TPTA_A_R1_CRIT: reg_rdata_q <= r1_crit_q;
                `TPTA_A_LOC_CRIT: reg_rdata_q <= loc_crit_q;
                `TPTA_A_R2_CRIT: reg_rdata_q <= r2_crit_q;
                `TPTA_A_MASK_TWO: reg_rdata_q <= mask_two_q;
                `TPTA_A_CFG_THREE: reg_rdata_q <= cfg_three_q;
                `TPTA_A_TIMER: reg_rdata_q <= tmr_val;
                `TPTA_A_TIMER_LIMIT: reg_rdata_q <= tmr_limit_q;
                `TPTA_A_CFG_FOUR: reg_rdata_q <= cfg_four_q;
                default: reg_rdata_q <= `TPTA_ZERO_BYTE;
            endcase
        end
    end

endmodule

`default_nettype wire

//--- bench/tpta_chk.sv
/*
 * Concurrent checks on the thermal pin block, bound to tpta_top.
 * Sees only the top ports and keeps its own copies of the config registers.
 */
`timescale 1ns/1ps
`default_nettype none
module tpta_chk #(
    parameter TICK_CYCLES = 4
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata_q,
    input wire logic pin9_i,
    input wire logic pin5_oe_q,
    input wire logic fourth_tach_input_q,
    input wire logic fan_manual_mode,
    input wire logic [7:0] fan_manual_duty,
    input wire logic fan_above_start,
    input wire logic fan_full_speed_q
);
    logic [7:0] cfg3_q;
    logic [7:0] cfg4_q;
    logic [7:0] mask_q;
    logic [7:0] lim_q;
    wire thermal_event_pin_w = cfg4_q[1:0] == 2'h1 && cfg3_q[1];
    wire run_w = fan_manual_mode ? fan_manual_duty != 8'h00 : fan_above_start;
    wire rd_tmr_w = reg_rd && reg_addr == 8'h79;
    wire hot_w = thermal_event_pin_w && cfg3_q[2] && run_w && !pin9_i;
    wire hit_w = thermal_event_pin_w && cfg3_q[0] && !mask_q[5] && lim_q == 8'h00 && !pin9_i && !reg_rd;

    // ----------------------------------------------------------------
    // Register shadows
    // ----------------------------------------------------------------
    // Writes land at the strobe edge, so shadows track the design exactly
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            cfg3_q <= 8'h00;
            cfg4_q <= 8'h00;
            mask_q <= 8'h00;
            lim_q <= 8'h00;
        end
        else if (reg_wr)
        begin
            case (reg_addr)
                8'h78: cfg3_q <= reg_wdata;
                8'h7D: cfg4_q <= reg_wdata;
                8'h75: mask_q <= reg_wdata;
                8'h7A: lim_q <= reg_wdata;
                default: ;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    // Released pin long enough that the synchroniser is clear, then two reads
    sequence s_quiet_reads;
        pin9_i [*4] ##0 rd_tmr_w ##1 rd_tmr_w;
    endsequence

    full_speed_override_full_a: assert property (hot_w [*4] |-> fan_full_speed_q)
        else $error("full speed missing while pin held low");
    full_speed_override_off_a: assert property ((!cfg3_q[2]) [*2] |-> !fan_full_speed_q)
        else $error("full speed without override");
    fan_idle_a: assert property ((!run_w) [*2] |-> !fan_full_speed_q)
        else $error("full speed on a stopped fan");
    alert_off_a: assert property ((!cfg3_q[0]) [*2] |-> !pin5_oe_q)
        else $error("alert pin driven while disabled");
    limit_alert_a: assert property (hit_w [*7] |-> pin5_oe_q)
        else $error("alert missing on zero timer limit");
    mask_all_a: assert property ((cfg3_q[0] && mask_q == 8'hFE) [*2] |-> !pin5_oe_q)
        else $error("alert driven with every source masked");
    read_clear_a: assert property (s_quiet_reads |-> ##2 reg_rdata_q == 8'h00)
        else $error("timer not cleared by read");
    tach_idle_a: assert property ((cfg4_q[1:0] != 2'h0) [*2] |-> fourth_tach_input_q)
        else $error("tach input not parked high");
    tach_pass_a: assert property ((cfg4_q[1:0] == 2'h0 && !pin9_i) [*4] |-> !fourth_tach_input_q)
        else $error("tach input does not follow the pin");
endmodule

bind tpta_top tpta_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
    .clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .pin9_i(pin9_i), .pin5_oe_q(pin5_oe_q),
    .fourth_tach_input_q(fourth_tach_input_q), .fan_manual_mode(fan_manual_mode),
    .fan_manual_duty(fan_manual_duty), .fan_above_start(fan_above_start),
    .fan_full_speed_q(fan_full_speed_q)
);
`default_nettype wire

//--- bench/tpta_hot_model.sv
/*
 * External hot-signal source on the ninth pin.
 * Assumes a pull-up on the line; the bench resolves the wire level.
 */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Open-drain source
// ----------------------------------------------------------------
module tpta_hot_model (
    input wire logic hot_req,
    output logic pull_low
);
    // Only ever sinks the line; release hands it back to the pull-up
    assign pull_low = hot_req;
endmodule
`default_nettype wire

//--- bench/tb.sv
/*
 * Self-checking bench for tpta_top with the hot-signal model on the ninth pin.
 * Assumes a pull-up on that pin and a shortened timer tick.
 */
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam int TICK = 4;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic upd = 1'b0;
    logic tc = 1'b0;
    logic hot_req = 1'b0;
    logic man = 1'b0;
    logic above = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic [7:0] duty = 8'h00;
    logic [9:0] t1 = 10'h000;
    logic [5:0] f = 6'h00;
    logic [7:0] rdata;
    logic oe9, oe5, tach, full, pull_low;
    int num_errors = 0;
    int comparisons = 0;
    // Pull-up: low whenever any party sinks the line
    wire pin9 = ~(pull_low | oe9);

    // ----------------------------------------------------------------
    // Design, partner and clock
    // ----------------------------------------------------------------
    tpta_top #(.TICK_CYCLES(TICK)) DUT (
        .clk(clk), .nrst(nrst), .reg_addr(addr), .reg_wr(reg_wr), .reg_wdata(wdata), .reg_rd(reg_rd),
        .reg_rdata_q(rdata), .pin9_i(pin9), .pin9_oe_q(oe9), .pin5_oe_q(oe5), .fourth_tach_input_q(tach),
        .temp_r1(t1), .temp_loc(10'h000), .temp_r2(10'h000), .temp_update(upd), .twos_mode(tc),
        .fan_manual_mode(man), .fan_manual_duty(duty), .fan_above_start(above),
        .diode2_fault(f[5]), .diode1_fault(f[4]), .fourth_cooler_fail(f[3]), .third_cooler_fail(f[2]),
        .second_cooler_fail(f[1]), .first_cooler_fail(f[0]), .fan_full_speed_q(full)
    );
    tpta_hot_model u_hot (.hot_req(hot_req), .pull_low(pull_low));
    always #20 clk = ~clk;

    // ----------------------------------------------------------------
    // Port tasks and compares
    // ----------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_wr = 1'b1;
        addr = a;
        wdata = d;
        @(negedge clk);
        reg_wr = 1'b0;
    endtask
    // Extra edge of slack before sampling; read data holds until the next read
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        reg_rd = 1'b1;
        addr = a;
        @(negedge clk);
        reg_rd = 1'b0;
        @(negedge clk);
        d = rdata;
    endtask
    task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chkbit(input string what, input logic exp, input logic got);
        chk8(what, {7'h00, exp}, {7'h00, got});
    endtask
    task automatic chkrd(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rd(a, d);
        chk8($sformatf("reg %h", a), exp, d);
    endtask
    task automatic hold_low(input int n);
        @(negedge clk);
        hot_req = 1'b1;
        repeat (n) @(negedge clk);
        hot_req = 1'b0;
    endtask
    task automatic pulse_update(input logic [9:0] t);
        t1 = t;
        @(negedge clk);
        upd = 1'b1;
        @(negedge clk);
        upd = 1'b0;
        repeat (4) @(negedge clk);
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    // Reset values, read-back, and refused writes to status, timer and holes
    task automatic t_regs;
        logic [7:0] regs [14] = '{8'h5F, 8'h60, 8'h61, 8'h6A, 8'h6B, 8'h6C, 8'h75, 8'h78, 8'h7A, 8'h7D,
                                  8'h79, 8'h42, 8'h00, 8'hFF};
        chkbit("tach idle", 1'b1, tach);
        foreach (regs[i]) chkrd(regs[i], 8'h00);
        foreach (regs[i]) wr(regs[i], regs[i]);
        foreach (regs[i]) chkrd(regs[i], i < 10 ? regs[i] : 8'h00);
        foreach (regs[i]) wr(regs[i], 8'h00);
    endtask
    // Cumulative count, pause, clear on read and saturation
    task automatic t_timer;
        wr(8'h7D, 8'h01);
        wr(8'h78, 8'h02);
        wr(8'h7A, 8'hFF);
        hold_low(2);
        repeat (4) @(negedge clk);
        chkrd(8'h79, 8'h01);
        chkrd(8'h79, 8'h00);
        hold_low(9);
        repeat (5) @(negedge clk);
        hold_low(9);
        repeat (5) @(negedge clk);
        chkrd(8'h79, 8'h04);
        hold_low(1100);
        chkrd(8'h79, 8'hFF);
        @(negedge clk);
        reg_rd = 1'b1;
        addr = 8'h79;
        repeat (2) @(negedge clk);
        reg_rd = 1'b0;
        chkrd(8'h79, 8'h00);
    endtask
    // Timer limit flag, alert, read during assertion, and masking
    task automatic t_alert;
        logic [7:0] d;
        wr(8'h7A, 8'h00);
        wr(8'h78, 8'h03);
        hot_req = 1'b1;
        repeat (8) @(negedge clk);
        chkbit("alert pin", 1'b1, oe5);
        rd(8'h79, d);
        chkrd(8'h42, 8'h20);
        hot_req = 1'b0;
        repeat (4) @(negedge clk);
        rd(8'h79, d);
        chkrd(8'h42, 8'h00);
        repeat (3) @(negedge clk);
        chkbit("alert released", 1'b0, oe5);
        wr(8'h7A, 8'h01);
        hold_low(5);
        chkrd(8'h42, 8'h00);
        hold_low(5);
        chkrd(8'h42, 8'h20);
        rd(8'h79, d);
        wr(8'h75, 8'h20);
        wr(8'h7A, 8'h00);
        hold_low(8);
        chkbit("masked alert", 1'b0, oe5);
        chkrd(8'h42, 8'h20);
        rd(8'h79, d);
        wr(8'h75, 8'h00);
    endtask
    // Rows: override, manual, duty nonzero, above start, expected full speed
    task automatic t_fan;
        logic [4:0] tab [5] = '{5'b11101, 5'b11000, 5'b10011, 5'b10000, 5'b01100};
        foreach (tab[i])
        begin
            wr(8'h78, tab[i][4] ? 8'h06 : 8'h02);
            man = tab[i][3];
            duty = tab[i][2] ? 8'h40 : 8'h00;
            above = tab[i][1];
            hot_req = 1'b1;
            repeat (6) @(negedge clk);
            chkbit("full speed", tab[i][0], full);
            hot_req = 1'b0;
            repeat (6) @(negedge clk);
            chkbit("full speed released", 1'b0, full);
        end
    endtask
    // Critical drive: quarter degree over, at the limit, disabled limit
    task automatic t_crit;
        wr(8'h5F, 8'h08);
        wr(8'h6A, 8'h90);
        pulse_update({8'h90, 2'h1});
        chkbit("critical drive", 1'b1, oe9);
        pulse_update({8'h90, 2'h0});
        chkbit("critical at limit", 1'b0, oe9);
        wr(8'h6A, 8'h80);
        pulse_update({8'hA0, 2'h0});
        chkbit("critical disabled", 1'b0, oe9);
        tc = 1'b1;
        wr(8'h6A, 8'h50);
        pulse_update({8'h50, 2'h1});
        chkbit("signed drive", 1'b1, oe9);
        pulse_update({8'hF0, 2'h0});
        chkbit("signed below zero", 1'b0, oe9);
        wr(8'h6A, 8'h90);
        pulse_update({8'hA0, 2'h0});
        chkbit("signed disabled", 1'b0, oe9);
        tc = 1'b0;
    endtask
    // Each fault source: status bit, alert, mask and sticky clearing
    task automatic t_faults;
        logic [7:0] d;
        rd(8'h79, d);
        rd(8'h42, d);
        wr(8'h7D, 8'h00);
        wr(8'h78, 8'h01);
        hot_req = 1'b1;
        repeat (5) @(negedge clk);
        chkbit("tach follows pin", 1'b0, tach);
        hot_req = 1'b0;
        for (int i = 0; i < 6; i++)
        begin
            f = 6'h01 << i;
            repeat (3) @(negedge clk);
            chkbit("fault alert", 1'b1, oe5);
            wr(8'h75, 8'h04 << i);
            chkrd(8'h42, 8'h04 << i);
            chkbit("fault masked", 1'b0, oe5);
            f = 6'h00;
            chkrd(8'h42, 8'h04 << i);
            chkrd(8'h42, 8'h00);
            wr(8'h75, 8'h00);
        end
        f = 6'h01;
        wr(8'h7D, 8'h02);
        repeat (2) @(negedge clk);
        chkbit("pin9 alert", 1'b1, oe9);
        wr(8'h7D, 8'h03);
        repeat (2) @(negedge clk);
        chkbit("pin9 gpio", 1'b0, oe9);
        f = 6'h00;
        rd(8'h42, d);
        wr(8'h75, 8'hFE);
        repeat (3) @(negedge clk);
        chkbit("all masked", 1'b0, oe5);
    endtask

    // ----------------------------------------------------------------
    // Run control
    // ----------------------------------------------------------------
    task automatic wrap_up;
        $display("comparisons %0d num_errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // Cuts a hang short at 100000 cycles, well above the expected run length
    initial
    begin
        repeat (100000) @(posedge clk);
        num_errors++;
        $display("[FAIL] run length expected finish seen timeout");
        wrap_up();
    end
    initial
    begin
        repeat (20) @(negedge clk);
        nrst = 1'b1;
        t_regs();
        t_timer();
        t_alert();
        t_fan();
        t_crit();
        t_faults();
        wrap_up();
    end
endmodule
`default_nettype wire
